// ---- hw/smb_map.svh ----
// Register map, field positions and fixed counts of the sensor monitor back-end.
`ifndef SMB_MAP_SVH
`define SMB_MAP_SVH
`define SMB_A_CTRL      8'h00
`define SMB_A_CYCLE_CLOCK_COUNT      8'h04
`define SMB_A_PERS      8'h08
`define SMB_A_THR0      8'h0C
`define SMB_A_THR1      8'h10
`define SMB_A_HYST      8'h14
`define SMB_A_STAT      8'h18
`define SMB_A_FLAG      8'h1C
`define SMB_A_FIFO      8'h20
`define SMB_A_ACC0      8'h24
`define SMB_A_ACC1      8'h28
`define SMB_C_OSC       0
`define SMB_C_LAUNCH    1
`define SMB_C_ABORT     2
`define SMB_C_HP        3
`define SMB_C_FMT       4
`define SMB_C_POL       5
`define SMB_C_GEN       6
`define SMB_C_SCAN      9:8
`define SMB_C_CHEN      11:10
`define SMB_CTRL_WMASK  32'h0000_0F79
`define SMB_DEPTH       5'h10
`define SMB_NSUM        5'h10
`define SMB_ADDR_UP     7'h1F
`define SMB_ADDR_LO     7'h18
`define SMB_GC_ADDR     8'h00
`define SMB_GC_SWRST    8'h06
`define SMB_GC_PROG     8'h04
`define SMB_HS_CODE     5'h01
`define SMB_PROG_HOLD   2'h3
`define SMB_CYCLE_CLOCK_COUNT_RST    16'h0010
`endif

// ---- hw/smb_pkg.sv ----
// Types shared by the sensor monitor back-end.
package smb_pkg;
  typedef enum logic {SEQ_IDLE, SEQ_RUN} smb_seq_t;
  typedef enum logic [1:0] {GC_IDLE, GC_FIRST, GC_CMD, GC_SKIP} smb_gc_t;
endpackage

// ---- hw/smb_wcomp.sv ----
// Per-channel window comparator with hysteresis, persistence count and latched flags.
`timescale 1ns/100ps
`default_nettype none
module smb_wcomp (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic        res_vld,
  input  wire logic [11:0] res,
  input  wire logic [11:0] thr_hi,
  input  wire logic [11:0] thr_lo,
  input  wire logic [11:0] hys,
  input  wire logic [7:0]  limit,
  input  wire logic [1:0]  flag_clr,
  output logic      [1:0]  flag_ff
);
  logic [1:0] out_ff;
  wire        take = res_vld & en;

  // Side 0 watches the high threshold, side 1 the low threshold.
  for (genvar s = 0; s < 2; s++) begin : g_side
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic       nxt_out;
    logic       trip;
    logic       rel;
    always_comb begin
      if (s == 0) begin
        trip = {1'b0, res} > {1'b0, thr_hi};
        rel  = ({1'b0, res} + {1'b0, hys}) < {1'b0, thr_hi};
      end else begin
        trip = {1'b0, res} < {1'b0, thr_lo};
        rel  = {1'b0, res} > ({1'b0, thr_lo} + {1'b0, hys});
      end
      nxt_out = trip | (out_ff[s] & ~rel); // R18
      // The first conversion that trips starts the count at zero.
      nxt_cnt = (nxt_out & out_ff[s] & (cnt_ff != 8'hFF)) ? cnt_ff + 8'h01 :
                (nxt_out & out_ff[s]) ? cnt_ff : 8'h00; // R19
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        out_ff[s]  <= 1'b0;
        cnt_ff     <= 8'h00;
        flag_ff[s] <= 1'b0;
      end else if (ce) begin
        if (clr) begin
          out_ff[s]  <= 1'b0;
          cnt_ff     <= 8'h00;
          flag_ff[s] <= 1'b0;
        end else begin
          if (take) begin
            out_ff[s] <= nxt_out;
            cnt_ff    <= nxt_cnt;
          end
          // A new event beats a clear that lands in the same cycle.
          flag_ff[s] <= (take & nxt_out & (nxt_cnt >= limit)) |
                        (flag_ff[s] & ~flag_clr[s]); // R19 R20
        end
      end
    end
  end

  a_flag_cause: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    $rose(flag_ff[0]) |-> $past(take) && out_ff[0]) // R19
    else $error("High flag set without a tripped conversion.");
  a_flag_w1c: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    flag_ff[0] && flag_clr[0] && !take |=> !flag_ff[0]) // R20
    else $error("High flag survived a write-one clear.");
endmodule
`default_nettype wire

// ---- hw/smb_top.sv ----
// Sensor monitor back-end: APB registers, conversion timing, buffer, accumulators.
//
// Notes on behaviour
// R1: Oscillator choice 1 low-power, 0 high-speed.
// R2: Conversion lasts cycle_clock_count oscillator ticks.
// R3: Same-channel spacing is channels times cycle.
// R4: Strap address latched at power-up, reset, reprogram.
// R5: Strap decodes to addresses 18h through 1Fh.
// R6: Buffer holds sixteen sixteen-bit entries.
// R7: Fill policy governs writing; fill level readable.
// R8: Optional channel identifier and entry-valid flag.
// R9: Unfilled or excess reads give zero, invalid.
// R10: Fill in conversion order, unfilled entries zero.
// R11: Activity pin low on completion or abort.
// R12: Reads pop oldest first; zeros when busy.
// R13: Master ends buffer read with NACK, STOP.
// R14: Buffer cleared on launch and reset.
// R15: High precision sums sixteen results per channel.
// R16: Summation count readable; cleared on launch, reset.
// R17: Comparator needs global and channel enable.
// R18: High and low outputs with hysteresis.
// R19: Persistence count sets latched flag.
// R20: Write one clears flag; alert re-evaluated.
// R21: Acknowledge general call; 06h resets device.
// R22: General call 04h re-reads strap, stays busy.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "smb_map.svh"
module smb_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lpo_tick,
  input  wire logic        hso_tick,
  input  wire logic [11:0] adc_code,
  input  wire logic [2:0]  addr_strap,
  input  wire logic        i2c_start,
  input  wire logic        i2c_stop,
  input  wire logic        i2c_byte_vld,
  input  wire logic [7:0]  i2c_byte,
  output logic             gc_ack,
  output logic             activity,
  output logic             alert,
  output logic             fast_speed_flag,
  output logic      [6:0]  dev_addr,
  output logic             conv_ch,
  output logic             conv_done
);
  logic [31:0]     ctrl_ff;
  logic [15:0]     cycle_clock_count;
  logic [7:0]      persistence_limit;
  logic [31:0]     thr_ff [2];
  logic [31:0]     hyst_ff;
  smb_pkg::smb_seq_t seq_ff;
  smb_pkg::smb_gc_t  gc_ff;
  logic [15:0]     clk_cnt_ff;
  logic [11:0]     res_ff;
  logic [3:0]      wptr_ff;
  logic [4:0]      fill_ff;
  logic [4:0]      rd_cnt_ff;
  logic [4:0]      sum_cnt_ff;
  logic [15:0]     acc_ff [2];
  logic [12:0]     mem_ff [16];
  logic [15:0]     vld_ff;
  logic [1:0]      flag_hi;
  logic [1:0]      flag_lo;
  logic            srst_ff;
  logic [1:0]      hold_ff;
  logic            strap_pend_ff;
  logic [31:0]     nxt_rd;

  wire oscillator_choice        = ctrl_ff[`SMB_C_OSC];
  wire hp_mode                  = ctrl_ff[`SMB_C_HP];
  wire fmt_en                   = ctrl_ff[`SMB_C_FMT];
  wire buffer_fill_policy       = ctrl_ff[`SMB_C_POL];
  wire comparator_global_enable = ctrl_ff[`SMB_C_GEN];
  wire [1:0] scan_channel_select       = ctrl_ff[`SMB_C_SCAN];
  wire [1:0] comparator_channel_enable = ctrl_ff[`SMB_C_CHEN];

  // APB: one wait state; the write lands at the edge where pready is seen.
  wire setup_ph = psel & penable & ~pready;
  wire acc_ph   = psel & penable & pready;
  // While the strap is being re-read APB writes are ignored; only general calls and reads are obeyed.
  wire wr_go    = acc_ph & pwrite & (hold_ff == 2'h0); // R22
  wire rd_pop   = acc_ph & ~pwrite & (paddr == `SMB_A_FIFO);
  // The scan selection written with the launch decides, so a first launch is not refused.
  wire sequence_launch_bit = wr_go & (paddr == `SMB_A_CTRL) &
                             pwdata[`SMB_C_LAUNCH] & (pwdata[`SMB_C_SCAN] != 2'h0);
  wire sequence_abort_bit  = wr_go & (paddr == `SMB_A_CTRL) & pwdata[`SMB_C_ABORT];
  wire running  = seq_ff == smb_pkg::SEQ_RUN;
  wire sel_tick = oscillator_choice ? lpo_tick : hso_tick; // R1
  wire [15:0] ncyc_m1 = (cycle_clock_count == 16'h0000) ? 16'h0000 :
                        cycle_clock_count - 16'h0001;
  wire conv_end = running & sel_tick & (clk_cnt_ff == ncyc_m1); // R2
  wire round_end = conv_ch | ~scan_channel_select[1];
  wire [1:0] flag_clr_hi = (wr_go & (paddr == `SMB_A_FLAG)) ? pwdata[1:0] : 2'h0;
  wire [1:0] flag_clr_lo = (wr_go & (paddr == `SMB_A_FLAG)) ? pwdata[3:2] : 2'h0;
  wire [3:0] rd_idx = wptr_ff - fill_ff[3:0] + rd_cnt_ff[3:0];
  wire wr_entry = conv_done & running & ~hp_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff           <= 32'h0000_0000;
      cycle_clock_count <= `SMB_CYCLE_CLOCK_COUNT_RST;
      persistence_limit <= 8'h00;
      thr_ff[0]         <= 32'h0000_0000;
      thr_ff[1]         <= 32'h0000_0000;
      hyst_ff           <= 32'h0000_0000;
    end else if (ce) begin
      if (srst_ff) begin
        ctrl_ff           <= 32'h0000_0000;
        cycle_clock_count <= `SMB_CYCLE_CLOCK_COUNT_RST;
        persistence_limit <= 8'h00;
        thr_ff[0]         <= 32'h0000_0000;
        thr_ff[1]         <= 32'h0000_0000;
        hyst_ff           <= 32'h0000_0000;
      end else if (wr_go) begin
        case (paddr)
          `SMB_A_CTRL: ctrl_ff <= pwdata & `SMB_CTRL_WMASK;
          `SMB_A_CYCLE_CLOCK_COUNT: cycle_clock_count <= pwdata[15:0];
          `SMB_A_PERS: persistence_limit <= pwdata[7:0];
          `SMB_A_THR0: thr_ff[0] <= pwdata & 32'h0FFF_0FFF;
          `SMB_A_THR1: thr_ff[1] <= pwdata & 32'h0FFF_0FFF;
          `SMB_A_HYST: hyst_ff <= pwdata & 32'h0FFF_0FFF;
          default: ;
        endcase
      end
    end
  end

  // Sequence control and conversion timing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_ff     <= smb_pkg::SEQ_IDLE;
      clk_cnt_ff <= 16'h0000;
      conv_ch    <= 1'b0;
      conv_done  <= 1'b0;
      res_ff     <= 12'h000;
    end else if (ce) begin
      conv_done <= conv_end;
      if (conv_end) begin
        res_ff <= adc_code;
      end
      if (srst_ff | sequence_abort_bit) begin
        seq_ff     <= smb_pkg::SEQ_IDLE; // R11
        clk_cnt_ff <= 16'h0000;
      end else if (sequence_launch_bit) begin
        seq_ff     <= smb_pkg::SEQ_RUN;
        clk_cnt_ff <= 16'h0000;
        conv_ch    <= ~pwdata[8];
      end else begin
        case (seq_ff)
          smb_pkg::SEQ_RUN: begin
            if (sel_tick) begin
              clk_cnt_ff <= conv_end ? 16'h0000 : clk_cnt_ff + 16'h0001;
            end
            // Toggle after the result pulse so every consumer of the result sees its channel.
            if (conv_done && scan_channel_select == 2'h3) begin
              conv_ch <= ~conv_ch; // R3
            end
            // Stop-when-full ends at sixteen entries; the ring policy only on abort or soft reset.
            if ((!hp_mode && !buffer_fill_policy && fill_ff == `SMB_DEPTH) ||
                (hp_mode && sum_cnt_ff == `SMB_NSUM)) begin
              seq_ff <= smb_pkg::SEQ_IDLE; // R7 R15
            end
          end
          smb_pkg::SEQ_IDLE: ;
          default: seq_ff <= smb_pkg::SEQ_IDLE;
        endcase
      end
    end
  end

  // Result buffer; each entry has its own clear and write enable.
  for (genvar i = 0; i < 16; i++) begin : g_entry
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem_ff[i] <= 13'h0000;
        vld_ff[i] <= 1'b0;
      end else if (ce) begin
        if (srst_ff | sequence_launch_bit) begin
          mem_ff[i] <= 13'h0000; // R10 R14
          vld_ff[i] <= 1'b0; // R9
        end else if (wr_entry && wptr_ff == 4'(i) &&
                     (buffer_fill_policy || fill_ff != `SMB_DEPTH)) begin
          mem_ff[i] <= {conv_ch, res_ff}; // R6 R10
          vld_ff[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_ff   <= 4'h0;
      fill_ff   <= 5'h00;
      rd_cnt_ff <= 5'h00;
    end else if (ce) begin
      if (srst_ff | sequence_launch_bit) begin
        wptr_ff   <= 4'h0; // R14
        fill_ff   <= 5'h00;
        rd_cnt_ff <= 5'h00;
      end else begin
        if (wr_entry && (buffer_fill_policy || fill_ff != `SMB_DEPTH)) begin
          wptr_ff <= wptr_ff + 4'h1;
          if (fill_ff != `SMB_DEPTH) begin
            fill_ff <= fill_ff + 5'h01; // R7
          end
        end
        if (rd_pop && !running && rd_cnt_ff < fill_ff) begin
          rd_cnt_ff <= rd_cnt_ff + 5'h01; // R12
        end
      end
    end
  end

  // High-precision accumulators, one per channel.
  for (genvar c = 0; c < 2; c++) begin : g_acc
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        acc_ff[c] <= 16'h0000;
      end else if (ce) begin
        if (srst_ff | sequence_launch_bit) begin
          acc_ff[c] <= 16'h0000; // R16
        end else if (conv_done && running && hp_mode && scan_channel_select[c] &&
                     conv_ch == 1'(c) && sum_cnt_ff != `SMB_NSUM) begin
          acc_ff[c] <= acc_ff[c] + {4'h0, res_ff}; // R15
        end
      end
    end
    smb_wcomp u_cmp (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (ce),
      .clr      (srst_ff),
      .en       (comparator_global_enable & comparator_channel_enable[c]), // R17
      .res_vld  (conv_done & conv_ch == 1'(c)),
      .res      (res_ff),
      .thr_hi   (thr_ff[c][11:0]),
      .thr_lo   (thr_ff[c][27:16]),
      .hys      (c == 0 ? hyst_ff[11:0] : hyst_ff[27:16]),
      .limit    (persistence_limit),
      .flag_clr ({flag_clr_lo[c], flag_clr_hi[c]}),
      .flag_ff  ({flag_lo[c], flag_hi[c]})
    );
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_cnt_ff <= 5'h00;
    end else if (ce) begin
      if (srst_ff | sequence_launch_bit) begin
        sum_cnt_ff <= 5'h00; // R16
      end else if (conv_done && running && hp_mode && round_end &&
                   sum_cnt_ff != `SMB_NSUM) begin
        sum_cnt_ff <= sum_cnt_ff + 5'h01;
      end
    end
  end

  // Read mux; buffer words are formatted on the way out.
  always_comb begin
    nxt_rd = 32'h0000_0000;
    case (paddr)
      `SMB_A_CTRL: nxt_rd = ctrl_ff;
      `SMB_A_CYCLE_CLOCK_COUNT: nxt_rd = {16'h0000, cycle_clock_count};
      `SMB_A_PERS: nxt_rd = {24'h00_0000, persistence_limit};
      `SMB_A_THR0: nxt_rd = thr_ff[0];
      `SMB_A_THR1: nxt_rd = thr_ff[1];
      `SMB_A_HYST: nxt_rd = hyst_ff;
      `SMB_A_STAT: nxt_rd = {1'b0, dev_addr, 3'h0, sum_cnt_ff, 3'h0, fill_ff,
                             6'h00, fast_speed_flag, activity};
      `SMB_A_FLAG: nxt_rd = {28'h000_0000, flag_lo, flag_hi};
      `SMB_A_FIFO: begin
        if (!running && rd_cnt_ff < fill_ff && vld_ff[rd_idx]) begin // R9 R12
          nxt_rd[15:0] = fmt_en ? {mem_ff[rd_idx][11:0], 2'h0, mem_ff[rd_idx][12], 1'b1}
                                : {4'h0, mem_ff[rd_idx][11:0]}; // R8
        end
      end
      `SMB_A_ACC0: nxt_rd = {16'h0000, acc_ff[0]};
      `SMB_A_ACC1: nxt_rd = {16'h0000, acc_ff[1]};
      default: nxt_rd = 32'h0000_0000;
    endcase
  end

  wire hit = (paddr <= `SMB_A_ACC1) && (paddr[1:0] == 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~hit;
      prdata  <= (setup_ph & ~pwrite) ? nxt_rd : 32'h0000_0000;
    end
  end

  // Pins: alert follows any latched flag, activity covers sequence and strap re-read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert    <= 1'b0;
      activity <= 1'b0;
    end else if (ce) begin
      alert    <= |{flag_hi, flag_lo}; // R20
      activity <= running | (hold_ff != 2'h0); // R11 R22
    end
  end

  // General call decoder on the byte stream of the bus front end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gc_ff           <= smb_pkg::GC_IDLE;
      gc_ack          <= 1'b0;
      srst_ff         <= 1'b0;
      fast_speed_flag <= 1'b0;
      hold_ff         <= 2'h0;
    end else if (ce) begin
      gc_ack  <= 1'b0;
      srst_ff <= 1'b0;
      if (hold_ff != 2'h0) begin
        hold_ff <= hold_ff - 2'h1;
      end
      if (i2c_stop) begin
        gc_ff           <= smb_pkg::GC_IDLE;
        fast_speed_flag <= 1'b0;
      end else if (i2c_start) begin
        gc_ff <= smb_pkg::GC_FIRST;
      end else if (i2c_byte_vld) begin
        case (gc_ff)
          smb_pkg::GC_FIRST: begin
            if (i2c_byte == `SMB_GC_ADDR) begin
              gc_ack <= 1'b1; // R21
              gc_ff  <= smb_pkg::GC_CMD;
            end else begin
              if (i2c_byte[7:3] == `SMB_HS_CODE) begin
                fast_speed_flag <= 1'b1;
              end
              gc_ff <= smb_pkg::GC_SKIP;
            end
          end
          smb_pkg::GC_CMD: begin
            srst_ff <= i2c_byte == `SMB_GC_SWRST; // R21
            if (i2c_byte == `SMB_GC_PROG) begin
              hold_ff <= `SMB_PROG_HOLD; // R22
            end
            gc_ff <= smb_pkg::GC_SKIP;
          end
          smb_pkg::GC_IDLE, smb_pkg::GC_SKIP: ;
          default: gc_ff <= smb_pkg::GC_IDLE;
        endcase
      end
    end
  end

  // The strap is caught one clock after release, after soft reset and on reprogram.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_pend_ff <= 1'b1;
      dev_addr      <= `SMB_ADDR_LO;
    end else if (ce) begin
      strap_pend_ff <= srst_ff | (hold_ff == 2'h2);
      if (strap_pend_ff) begin // R4
        dev_addr <= addr_strap[2] ? `SMB_ADDR_LO + {5'h00, addr_strap[1:0]}
                                  : `SMB_ADDR_UP - {5'h00, addr_strap[1:0]}; // R5
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  sequence s_launch_write;
    sequence_launch_bit;
  endsequence

  a_osc_source: assert property (conv_done |-> $past(sel_tick)) // R1
    else $error("Conversion ended without a tick of the chosen oscillator.");
  a_cycle_count: assert property (conv_done && $past(running) |->
    $past(clk_cnt_ff) == $past(ncyc_m1)) // R2
    else $error("Conversion ended at the wrong tick count.");
  a_addr_range: assert property (dev_addr[6:3] == 4'h3) // R5
    else $error("Bus address outside the strap range.");
  a_fill_bound: assert property (fill_ff <= `SMB_DEPTH && rd_cnt_ff <= fill_ff) // R6
    else $error("Buffer fill level out of range.");
  a_launch_clear: assert property (s_launch_write |=>
    fill_ff == 5'h00 && sum_cnt_ff == 5'h00 && acc_ff[0] == 16'h0000) // R14 R16
    else $error("Launch did not clear buffer and accumulators.");
  a_abort_idle: assert property (sequence_abort_bit |=> ##1 !activity || hold_ff != 2'h0) // R11
    else $error("Activity pin stayed high after abort.");
  a_busy_read: assert property (setup_ph && !pwrite && paddr == `SMB_A_FIFO && running
    |=> prdata == 32'h0000_0000) // R12
    else $error("Buffer read during a sequence returned data.");
  a_gc_ack: assert property (gc_ff == smb_pkg::GC_FIRST && i2c_byte_vld && !i2c_start &&
    !i2c_stop && i2c_byte == `SMB_GC_ADDR |=> gc_ack) // R21
    else $error("General call was not acknowledged.");
endmodule
`default_nettype wire

// ---- sim/smb_i2c_host.sv ----
// Behavioural bus master that feeds start, byte and stop events to the back-end.
`timescale 1ns/100ps
`default_nettype none
module smb_i2c_host (
  input  wire logic       pclk,
  output logic            i2c_start,
  output logic            i2c_stop,
  output logic            i2c_byte_vld,
  output logic      [7:0] i2c_byte
);
  initial begin
    i2c_start    = 1'b0;
    i2c_stop     = 1'b0;
    i2c_byte_vld = 1'b0;
    i2c_byte     = 8'h00;
  end
  // The byte lines show the inverse once released, so stale data never looks valid.
  task automatic send(input logic [1:0] kind, input logic [7:0] b);
    @(posedge pclk);
    i2c_start    <= kind == 2'h0;
    i2c_byte_vld <= kind == 2'h1;
    i2c_stop     <= kind == 2'h2;
    i2c_byte     <= b;
    @(posedge pclk);
    i2c_start    <= 1'b0;
    i2c_byte_vld <= 1'b0;
    i2c_stop     <= 1'b0;
    i2c_byte     <= ~b;
  endtask
  task automatic gcall(input logic [7:0] cmd);
    send(2'h0, 8'h00);
    send(2'h1, 8'h00);
    send(2'h1, cmd);
    send(2'h2, 8'h00);
  endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the sensor monitor back-end.
`timescale 1ns/100ps
`default_nettype none
`include "smb_map.svh"
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        lpo_tick, hso_tick, adc_inc, gc_ack, activity, alert, ce;
  logic        i2c_start, i2c_stop, i2c_byte_vld, fast_speed_flag, conv_ch, conv_done;
  logic [7:0]  paddr, i2c_byte;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] adc_code;
  logic [2:0]  addr_strap;
  logic [6:0]  dev_addr;
  logic [3:0]  tcnt;
  int          n_mismatch, n_checks, n_ack;

  smb_top DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .lpo_tick, .hso_tick, .adc_code, .addr_strap,
    .i2c_start, .i2c_stop, .i2c_byte_vld, .i2c_byte, .gc_ack, .activity, .alert,
    .fast_speed_flag, .dev_addr, .conv_ch, .conv_done);
  smb_i2c_host host (.pclk, .i2c_start, .i2c_stop, .i2c_byte_vld, .i2c_byte);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Low-power ticks every 4 cycles, high-speed every 2, so the two rates differ.
  always @(posedge pclk) begin
    tcnt     <= tcnt + 4'h1;
    lpo_tick <= tcnt[1:0] == 2'h0;
    hso_tick <= tcnt[0] == 1'b0;
    if (adc_inc && conv_done === 1'b1) adc_code <= adc_code + 12'h001;
    if (gc_ack === 1'b1) n_ack <= n_ack + 1;
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      print_verdict();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // Mode 0 waits for a result pulse, mode 1 for the activity pin to drop.
  task automatic waitfor(input int which, output int n);
    for (n = 0; n < 3000; n++) begin
      @(posedge pclk);
      if ((which == 0) ? (conv_done === 1'b1) : (activity === 1'b0)) return;
    end
    n_mismatch++;
    print_verdict();
  endtask

  task automatic t_addr();
    logic [6:0] tbl [8];
    int         k;
    tbl = '{7'h1F, 7'h1E, 7'h1D, 7'h1C, 7'h18, 7'h19, 7'h1A, 7'h1B};
    chk({25'h0, dev_addr}, 32'h0000_001D);
    apb(1'b1, `SMB_A_CYCLE_CLOCK_COUNT, 32'h0000_0005);
    addr_strap <= 3'h6;
    repeat (4) @(posedge pclk);
    chk({25'h0, dev_addr}, 32'h0000_001D);
    for (k = 0; k < 8; k++) begin
      addr_strap <= k[2:0];
      host.gcall(`SMB_GC_PROG);
      repeat (6) @(posedge pclk);
      chk({25'h0, dev_addr}, {25'h0, tbl[k]});
    end
    chk(32'(n_ack), 32'h0000_0008);
    host.gcall(`SMB_GC_SWRST);
    repeat (4) @(posedge pclk);
    rchk(`SMB_A_CYCLE_CLOCK_COUNT, 32'h0000_0010);
  endtask

  task automatic t_osc(input logic osc, input int exp);
    int n;
    apb(1'b1, `SMB_A_CYCLE_CLOCK_COUNT, 32'h0000_0004);
    apb(1'b1, `SMB_A_CTRL, 32'h0000_0102 | {31'h0, osc});
    waitfor(0, n);
    waitfor(0, n);
    chk(32'(n + 1), 32'(exp));
    apb(1'b1, `SMB_A_CTRL, 32'h0000_0104);
    repeat (2) @(posedge pclk);
    chk({31'h0, activity}, 32'h0000_0000);
  endtask

  task automatic t_fifo();
    int k;
    int n;
    adc_code <= 12'h200;
    adc_inc  <= 1'b1;
    apb(1'b1, `SMB_A_CTRL, 32'h0000_0312);
    rchk(`SMB_A_FIFO, 32'h0000_0000);
    apb(1'b0, `SMB_A_STAT, 32'h0000_0000);
    chk(rd & 32'h0000_1F00, 32'h0000_0000);
    waitfor(1, n);
    apb(1'b0, `SMB_A_STAT, 32'h0000_0000);
    chk(rd & 32'h0000_1F00, 32'h0000_1000);
    for (k = 0; k < 16; k++) begin
      apb(1'b0, `SMB_A_FIFO, 32'h0000_0000);
      chk(rd, {16'h0, 12'h200 + k[11:0], 2'b00, k[0], 1'b1});
    end
    rchk(`SMB_A_FIFO, 32'h0000_0000);
    adc_inc <= 1'b0;
  endtask

  task automatic t_cmp();
    int n;
    adc_code <= 12'h900;
    apb(1'b1, `SMB_A_THR0, 32'h0100_0800);
    apb(1'b1, `SMB_A_HYST, 32'h0000_0010);
    apb(1'b1, `SMB_A_PERS, 32'h0000_0002);
    apb(1'b1, `SMB_A_CTRL, 32'h0000_0502);
    repeat (4) waitfor(0, n);
    chk({31'h0, alert}, 32'h0000_0000);
    apb(1'b1, `SMB_A_CTRL, 32'h0000_0542);
    waitfor(0, n);
    waitfor(0, n);
    repeat (2) @(posedge pclk);
    chk({31'h0, alert}, 32'h0000_0000);
    waitfor(0, n);
    repeat (3) @(posedge pclk);
    chk({31'h0, alert}, 32'h0000_0001);
    apb(1'b1, `SMB_A_CTRL, 32'h0000_0044);
    rchk(`SMB_A_FLAG, 32'h0000_0001);
    apb(1'b1, `SMB_A_FLAG, 32'h0000_0001);
    rchk(`SMB_A_FLAG, 32'h0000_0000);
    chk({31'h0, alert}, 32'h0000_0000);
  endtask

  task automatic t_acc();
    int k;
    adc_code <= 12'h123;
    apb(1'b1, `SMB_A_CTRL, 32'h0000_010A);
    for (k = 0; k < 100; k++) begin
      apb(1'b0, `SMB_A_STAT, 32'h0000_0000);
      if (rd[20:16] === 5'h10) break;
    end
    chk({27'h0, rd[20:16]}, 32'h0000_0010);
    rchk(`SMB_A_ACC0, 32'h0000_1230);
    rchk(`SMB_A_ACC1, 32'h0000_0000);
    apb(1'b1, `SMB_A_CTRL, 32'h0000_010A);
    rchk(`SMB_A_ACC0, 32'h0000_0000);
  endtask

  // Ring policy keeps the sequence alive past sixteen entries.
  task automatic t_ring();
    int n;
    apb(1'b1, `SMB_A_CTRL, 32'h0000_0122);
    repeat (18) waitfor(0, n);
    chk({31'h0, activity}, 32'h0000_0001);
    apb(1'b0, `SMB_A_STAT, 32'h0000_0000);
    chk(rd & 32'h0000_1F00, 32'h0000_1000);
  endtask

  // A master code sets the fast flag until stop; a frozen clock enable blocks soft reset.
  task automatic t_hs();
    host.send(2'h0, 8'h00);
    host.send(2'h1, 8'h09);
    @(posedge pclk);
    chk({31'h0, fast_speed_flag}, 32'h0000_0001);
    host.send(2'h2, 8'h00);
    @(posedge pclk);
    chk({31'h0, fast_speed_flag}, 32'h0000_0000);
    ce <= 1'b0;
    host.gcall(`SMB_GC_SWRST);
    ce <= 1'b1;
    rchk(`SMB_A_CYCLE_CLOCK_COUNT, 32'h0000_0004);
  endtask

  // Reset in the middle of a sequence.
  task automatic t_rst();
    apb(1'b1, `SMB_A_CTRL, 32'h0000_0102);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    chk({25'h0, dev_addr}, 32'h0000_0018);
    chk({31'h0, activity}, 32'h0000_0000);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({25'h0, dev_addr}, 32'h0000_001B);
    apb(1'b0, `SMB_A_STAT, 32'h0000_0000);
    chk(rd & 32'h001F_1F01, 32'h0000_0000);
  endtask

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    lpo_tick = 1'b0;
    hso_tick = 1'b0;
    tcnt = 4'h0;
    adc_code = 12'h000;
    adc_inc = 1'b0;
    addr_strap = 3'h2;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_addr();
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    t_osc(1'b1, 16);
    t_osc(1'b0, 8);
    t_fifo();
    t_cmp();
    t_acc();
    t_ring();
    t_hs();
    t_rst();
    print_verdict();
  end
endmodule
`default_nettype wire
